// ---- rtl/fctm_pkg.sv ----
// constants, codes and carrier types for the field controller trip manager
package fctm_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    typedef logic [7:0] fctm_code_t;
    typedef logic [2:0] fctm_class_t;
    typedef logic [3:0][7:0] fctm_hist_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } fctm_bus_req_t;

    typedef struct packed {
        logic valid;
        fctm_code_t code;
    } fctm_trip_req_t;

    typedef struct packed {
        logic [15:0] armature_v;
        logic [15:0] flux_fb;
        logic [15:0] field_i_fb;
        logic [15:0] firing_angle;
        logic [15:0] flux_ref;
    } fctm_meas_t;

    typedef enum logic [3:0] {
        LEFT_BLANK = 4'b0001,
        LEFT_INHIBITED = 4'b0010,
        LEFT_TRIPPED = 4'b0100,
        LEFT_RUNNING = 4'b1000
    } fctm_left_t;

    typedef enum logic [3:0] {
        AL_NONE = 4'b0001,
        AL_HOT = 4'b0010,
        AL_FAIL = 4'b0100,
        AL_LINK = 4'b1000
    } fctm_alarm_t;

    // trip code ranges
    localparam fctm_code_t FATAL_HW_FIRST = 8'h01;
    localparam fctm_code_t FATAL_HW_LAST = 8'h0b;
    localparam fctm_code_t NONRES_HW_FIRST = 8'h11;
    localparam fctm_code_t NONRES_HW_LAST = 8'h1d;
    localparam fctm_code_t CODE_UNDERVOLTAGE = 8'h30;
    localparam fctm_code_t CODE_STORED_DATA = 8'h31;
    localparam fctm_code_t CODE_NONE = 8'h00;

    // priority classes, lower is more serious
    localparam fctm_class_t CLS_FATAL = 3'h1;
    localparam fctm_class_t CLS_UV = 3'h2;
    localparam fctm_class_t CLS_NONRES = 3'h3;
    localparam fctm_class_t CLS_EEF = 3'h4;
    localparam fctm_class_t CLS_NORMAL = 3'h5;
    localparam fctm_class_t CLS_NONE = 3'h7;

    // operating mode values
    localparam logic [1:0] MODE_STANDALONE = 2'h0;
    localparam logic [1:0] MODE_HOST = 2'h1;
    localparam logic [1:0] MODE_LEGACY = 2'h2;
    localparam logic [1:0] MODE_RST = MODE_STANDALONE;
    localparam logic ENABLE_RST = 1'b0;

    localparam logic [15:0] LOAD_DEFAULTS_CODE = 16'h03e8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESET = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_HIST = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_ARM_V = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_FLUX_FB = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_FIELD_I = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_FIRING = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_FLUX_REF = 8'h2c;

    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int IRQ_W = 5;
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_CLEAR = 1;
    localparam int IRQ_FAIL = 2;
    localparam int IRQ_LINK = 3;
    localparam int IRQ_HOT = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

    // reset lockout timing
    localparam real TRIP_LOCKOUT_S = 1.0;
    localparam real CLK_HZ = 200.0e6;
    localparam int LOCKOUT_CYC = int'(TRIP_LOCKOUT_S * CLK_HZ);
    localparam int LOCK_CNT_W = 28;

    function automatic fctm_class_t fctm_class_f(input fctm_code_t code);
        if (code >= FATAL_HW_FIRST && code <= FATAL_HW_LAST) begin
            return CLS_FATAL;
        end else if (code == CODE_UNDERVOLTAGE) begin
            return CLS_UV;
        end else if (code >= NONRES_HW_FIRST && code <= NONRES_HW_LAST) begin
            return CLS_NONRES;
        end else if (code == CODE_STORED_DATA) begin
            return CLS_EEF;
        end else begin
            return CLS_NORMAL;
        end
    endfunction : fctm_class_f

endpackage : fctm_pkg

// ---- rtl/fctm_hist.sv ----
// four-deep trip code history, entry 0 most recent
`timescale 1ns/100ps
`default_nettype none
module fctm_hist (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic push,
    input wire fctm_pkg::fctm_code_t code,
    output fctm_pkg::fctm_hist_t hist
);
    import fctm_pkg::*;

    typedef struct packed {
        fctm_hist_t h;
    } fctm_hist_st_t;

    fctm_hist_st_t s_r;
    fctm_hist_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.h = {s_r.h[2:0], code};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hist = s_r.h;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    hist_shift_a: assert property (
        push |=> hist[0] == $past(code) && hist[1] == $past(hist[0]) && hist[3] == $past(hist[2]))
        else $error("history did not shift on new trip");
    hist_keep_a: assert property (
        !push |=> hist == $past(hist))
        else $error("history changed without a trip");

endmodule : fctm_hist
`default_nettype wire

// ---- rtl/fctm_freeze.sv ----
// diagnostic measurement hold, tracks live values until a trip
`timescale 1ns/100ps
`default_nettype none
module fctm_freeze (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic hold,
    input wire fctm_pkg::fctm_meas_t live,
    output fctm_pkg::fctm_meas_t frozen
);
    import fctm_pkg::*;

    typedef struct packed {
        fctm_meas_t m;
    } fctm_freeze_st_t;

    fctm_freeze_st_t s_r;
    fctm_freeze_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // capture in the trip cycle too, hold starts after it
        if (!hold) begin
            s_nxt.m = live;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign frozen = s_r.m;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    freeze_hold_a: assert property (
        hold |=> frozen == $past(frozen))
        else $error("measurement moved while tripped");
    freeze_track_a: assert property (
        RST_N && !hold |=> frozen == $past(live))
        else $error("measurement not tracking while untripped");

endmodule : fctm_freeze
`default_nettype wire

// ---- rtl/fctm_trip_mgr.sv ----
// trip arbitration, reset policy, displays, alarms and register file
`timescale 1ns/100ps
`default_nettype none
module fctm_trip_mgr #(
    parameter int LOCKOUT_CYCLES = fctm_pkg::LOCKOUT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire fctm_pkg::fctm_bus_req_t BUS_REQ,
    output logic [fctm_pkg::DATA_W-1:0] BUS_RDATA,
    input wire fctm_pkg::fctm_trip_req_t TRIP_REQ,
    input wire logic SUPPLY_OK,
    input wire logic HEATSINK_WARN,
    input wire logic HOST_LINK_OK,
    input wire logic HOST_ENABLE,
    input wire logic RIBBON_PRESENT,
    input wire fctm_pkg::fctm_meas_t MEAS_LIVE,
    output logic FIRING_EN,
    output logic TRIPPED,
    output fctm_pkg::fctm_left_t LEFT_STATUS,
    output fctm_pkg::fctm_code_t RIGHT_CODE,
    output fctm_pkg::fctm_alarm_t RIGHT_ALARM,
    output logic IRQ
);
    import fctm_pkg::*;

    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCKOUT_CYCLES - 1);

    typedef struct packed {
        logic tripped;
        fctm_code_t code;
        fctm_class_t cls;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic lock_done;
        logic enable;
        logic [1:0] mode;
        logic armed;
        logic fail_al;
        logic link_prev;
        logic hot_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        fctm_left_t left;
        fctm_alarm_t alarm;
        fctm_code_t right_code;
        logic fire;
    } fctm_top_st_t;

    fctm_top_st_t s_r;
    fctm_top_st_t s_nxt;

    fctm_hist_t hist;
    fctm_meas_t frozen;
    fctm_class_t new_cls;
    logic take;
    logic reset_req;
    logic code_wr;
    logic load_req;
    logic clr_ok;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    function automatic logic run_ok_f(input logic [1:0] mode, input logic en, input logic host_en,
                                      input logic ribbon);
        if (mode == MODE_STANDALONE) begin
            return en;
        end else if (mode == MODE_HOST) begin
            return en && host_en;
        end else if (mode == MODE_LEGACY) begin
            return en && ribbon;
        end else begin
            return 1'b0;
        end
    endfunction : run_ok_f

    function automatic logic wr_hit_f(input fctm_bus_req_t req, input logic [ADDR_W-1:0] off);
        return req.wr && req.addr == off;
    endfunction : wr_hit_f

    // trip arbitration
    assign new_cls = fctm_class_f(TRIP_REQ.code);
    assign take = TRIP_REQ.valid && (!s_r.tripped || new_cls < s_r.cls);

    assign reset_req = wr_hit_f(BUS_REQ, OFF_RESET) && BUS_REQ.wdata[0];
    assign code_wr = wr_hit_f(BUS_REQ, OFF_CODE);
    assign load_req = code_wr && BUS_REQ.wdata[15:0] == LOAD_DEFAULTS_CODE;

    // class 1 and class 3 are absent here, so they never clear
    always_comb begin
        clr_ok = 1'b0;
        if (s_r.tripped) begin
            if (s_r.cls == CLS_UV) begin
                clr_ok = SUPPLY_OK;
            end else if (s_r.cls == CLS_EEF) begin
                clr_ok = reset_req && s_r.armed;
            end else if (s_r.cls == CLS_NORMAL) begin
                clr_ok = reset_req && s_r.lock_done;
            end else begin
                clr_ok = 1'b0;
            end
        end
    end

    assign w1c = wr_hit_f(BUS_REQ, OFF_IRQ_STAT) ? BUS_REQ.wdata[IRQ_W-1:0] : '0;

    always_comb begin
        ev = '0;
        ev[IRQ_TRIP] = take;
        ev[IRQ_CLEAR] = clr_ok && !take;
        ev[IRQ_FAIL] = load_req && s_r.enable;
        ev[IRQ_LINK] = s_r.link_prev && !HOST_LINK_OK;
        ev[IRQ_HOT] = !s_r.hot_prev && HEATSINK_WARN;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        s_nxt.link_prev = HOST_LINK_OK;
        s_nxt.hot_prev = HEATSINK_WARN;

        // a more serious new trip in the clear cycle wins over the clear
        if (take) begin
            s_nxt.tripped = 1'b1;
            s_nxt.code = TRIP_REQ.code;
            s_nxt.cls = new_cls;
            s_nxt.lock_cnt = '0;
            s_nxt.lock_done = 1'b0;
        end else if (clr_ok) begin
            s_nxt.tripped = 1'b0;
            s_nxt.cls = CLS_NONE;
            if (s_r.cls == CLS_EEF) begin
                s_nxt.armed = 1'b0;
            end
        end else if (s_r.tripped && !s_r.lock_done) begin
            // lockout runs from the moment the trip was raised
            if (s_r.lock_cnt == LOCK_LAST) begin
                s_nxt.lock_done = 1'b1;
            end else begin
                s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
            end
        end

        // parameter writes
        if (wr_hit_f(BUS_REQ, OFF_CTRL)) begin
            s_nxt.enable = BUS_REQ.wdata[CTRL_ENABLE_BIT];
            s_nxt.mode = BUS_REQ.wdata[CTRL_MODE_LSB +: 2];
            if (!BUS_REQ.wdata[CTRL_ENABLE_BIT]) begin
                s_nxt.fail_al = 1'b0;
            end
        end
        if (load_req) begin
            if (s_r.enable) begin
                s_nxt.fail_al = 1'b1;
            end else begin
                s_nxt.armed = 1'b1;
                s_nxt.mode = MODE_RST;
            end
        end
        if (wr_hit_f(BUS_REQ, OFF_IRQ_MASK)) begin
            s_nxt.irq_mask = BUS_REQ.wdata[IRQ_W-1:0];
        end
        // new events beat a write-one-to-clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;

        // register reads, data one cycle after the strobe
        if (BUS_REQ.rd) begin
            if (BUS_REQ.addr == OFF_CTRL) begin
                s_nxt.rdata = {29'h0, s_r.mode, s_r.enable};
            end else if (BUS_REQ.addr == OFF_STATUS) begin
                s_nxt.rdata = {8'h00, s_r.fail_al, s_r.armed, s_r.lock_done, s_r.tripped,
                               1'b0, s_r.cls, s_r.code, s_r.right_code};
            end else if (BUS_REQ.addr == OFF_IRQ_STAT) begin
                s_nxt.rdata = {27'h0, s_r.irq_stat};
            end else if (BUS_REQ.addr == OFF_IRQ_MASK) begin
                s_nxt.rdata = {27'h0, s_r.irq_mask};
            end else if (BUS_REQ.addr == OFF_HIST) begin
                s_nxt.rdata = hist;
            end else if (BUS_REQ.addr == OFF_ARM_V) begin
                s_nxt.rdata = {16'h0, frozen.armature_v};
            end else if (BUS_REQ.addr == OFF_FLUX_FB) begin
                s_nxt.rdata = {16'h0, frozen.flux_fb};
            end else if (BUS_REQ.addr == OFF_FIELD_I) begin
                s_nxt.rdata = {16'h0, frozen.field_i_fb};
            end else if (BUS_REQ.addr == OFF_FIRING) begin
                s_nxt.rdata = {16'h0, frozen.firing_angle};
            end else if (BUS_REQ.addr == OFF_FLUX_REF) begin
                s_nxt.rdata = {16'h0, frozen.flux_ref};
            end else begin
                // code entry, reset and unmapped offsets read as zero
                s_nxt.rdata = '0;
            end
        end

        // left display, trip first, then enable, then run permission
        if (s_r.tripped) begin
            s_nxt.left = LEFT_TRIPPED;
        end else if (!s_r.enable) begin
            s_nxt.left = LEFT_INHIBITED;
        end else if (run_ok_f(s_r.mode, s_r.enable, HOST_ENABLE, RIBBON_PRESENT)) begin
            s_nxt.left = LEFT_RUNNING;
        end else begin
            s_nxt.left = LEFT_BLANK;
        end
        s_nxt.right_code = s_r.tripped ? s_r.code : CODE_NONE;

        // link loss matters most, since host control is gone
        if (!HOST_LINK_OK) begin
            s_nxt.alarm = AL_LINK;
        end else if (s_r.fail_al) begin
            s_nxt.alarm = AL_FAIL;
        end else if (HEATSINK_WARN) begin
            s_nxt.alarm = AL_HOT;
        end else begin
            s_nxt.alarm = AL_NONE;
        end

        // firing follows the next trip state so it drops with the trip flag
        s_nxt.fire = !s_nxt.tripped && run_ok_f(s_nxt.mode, s_nxt.enable, HOST_ENABLE,
                                                  RIBBON_PRESENT);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '{tripped: 1'b0, code: CODE_NONE, cls: CLS_NONE, lock_cnt: '0,
                     lock_done: 1'b0, enable: ENABLE_RST, mode: MODE_RST, armed: 1'b0,
                     fail_al: 1'b0, link_prev: 1'b1, hot_prev: 1'b0, irq_stat: '0,
                     irq_mask: IRQ_MASK_RST, rdata: '0, left: LEFT_INHIBITED,
                     alarm: AL_NONE, right_code: CODE_NONE, fire: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    fctm_hist u_hist (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .push(take),
        .code(TRIP_REQ.code),
        .hist(hist)
    );

    // live inputs are never gated by the trip, only the readback copy holds
    fctm_freeze u_freeze (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .hold(s_r.tripped),
        .live(MEAS_LIVE),
        .frozen(frozen)
    );

    assign BUS_RDATA = s_r.rdata;
    assign FIRING_EN = s_r.fire;
    assign TRIPPED = s_r.tripped;
    assign LEFT_STATUS = s_r.left;
    assign RIGHT_CODE = s_r.right_code;
    assign RIGHT_ALARM = s_r.alarm;
    assign IRQ = |(s_r.irq_stat & s_r.irq_mask);

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    ignore_lesser_a: assert property (
        s_r.tripped && TRIP_REQ.valid && fctm_class_f(TRIP_REQ.code) >= s_r.cls
        |=> s_r.code == $past(s_r.code))
        else $error("less serious trip replaced the active one");
    fatal_hold_a: assert property (
        s_r.tripped && s_r.cls == CLS_FATAL |=> s_r.tripped && s_r.cls == CLS_FATAL && !FIRING_EN)
        else $error("fatal hardware fault left its state");
    nonres_hold_a: assert property (
        s_r.tripped && s_r.cls == CLS_NONRES |=> s_r.tripped)
        else $error("non-resettable fault was cleared");
    uv_user_a: assert property (
        s_r.tripped && s_r.cls == CLS_UV && !SUPPLY_OK |=> s_r.tripped)
        else $error("undervoltage cleared with supply out of spec");
    uv_auto_a: assert property (
        s_r.tripped && s_r.cls == CLS_UV && SUPPLY_OK && !TRIP_REQ.valid |=> !s_r.tripped)
        else $error("undervoltage did not self clear");
    eef_guard_a: assert property (
        s_r.tripped && s_r.cls == CLS_EEF && !s_r.armed |=> s_r.tripped)
        else $error("stored-data error cleared without defaults");
    lockout_hold_a: assert property (
        s_r.tripped && s_r.cls == CLS_NORMAL && !s_r.lock_done |=> s_r.tripped)
        else $error("normal trip reset inside lockout");
    lockout_len_a: assert property (
        $rose(s_r.lock_done) |-> $past(s_r.lock_cnt) == LOCK_LAST && s_r.tripped)
        else $error("lockout length wrong");
    fire_off_a: assert property (
        s_r.tripped |-> !FIRING_EN)
        else $error("firing enabled while tripped");
    trip_disp_a: assert property (
        s_r.tripped |=> LEFT_STATUS == LEFT_TRIPPED && RIGHT_CODE == $past(s_r.code))
        else $error("trip not shown on displays");
    inhibit_disp_a: assert property (
        !s_r.tripped && !s_r.enable |=> LEFT_STATUS == LEFT_INHIBITED)
        else $error("inhibited status missing");
    fail_alarm_a: assert property (
        load_req && s_r.enable && HOST_LINK_OK ##1 HOST_LINK_OK |=> RIGHT_ALARM == AL_FAIL)
        else $error("default-failed alarm missing");
    // sampled reset term, the release edge itself still loads reset values
    link_alarm_a: assert property (
        RST_N && !HOST_LINK_OK |=> RIGHT_ALARM == AL_LINK)
        else $error("link loss alarm missing");
    hot_alarm_a: assert property (
        RST_N && HEATSINK_WARN && HOST_LINK_OK && !s_r.fail_al |=> RIGHT_ALARM == AL_HOT)
        else $error("heatsink warning not shown");
    take_new_a: assert property (
        !s_r.tripped && TRIP_REQ.valid |=> s_r.tripped && s_r.code == $past(TRIP_REQ.code))
        else $error("trip not registered while untripped");
    serious_wins_a: assert property (
        s_r.tripped && TRIP_REQ.valid && fctm_class_f(TRIP_REQ.code) < s_r.cls
        |=> s_r.tripped && s_r.code == $past(TRIP_REQ.code))
        else $error("more serious trip did not replace the active one");
    eef_clear_a: assert property (
        s_r.tripped && s_r.cls == CLS_EEF && s_r.armed && reset_req && !TRIP_REQ.valid
        |=> !s_r.tripped && !s_r.armed)
        else $error("stored-data error not cleared after defaults");
    norm_reset_a: assert property (
        s_r.tripped && s_r.cls == CLS_NORMAL && s_r.lock_done && reset_req && !TRIP_REQ.valid
        |=> !s_r.tripped)
        else $error("normal trip not cleared after lockout");
    run_stand_a: assert property (
        !s_r.tripped && s_r.enable && s_r.mode == MODE_STANDALONE |=> LEFT_STATUS == LEFT_RUNNING)
        else $error("running status missing in standalone mode");
    run_host_a: assert property (
        !s_r.tripped && s_r.enable && s_r.mode == MODE_HOST && !HOST_ENABLE |=> LEFT_STATUS == LEFT_BLANK)
        else $error("running shown without host permission");

endmodule : fctm_trip_mgr
`default_nettype wire

// ---- verification/fctm_host_model.sv ----
// host drive stand-in: link state, host run permission, live measurements
`timescale 1ns/100ps
`default_nettype none
module fctm_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_up,
    input wire logic run_req,
    output logic link_ok,
    output logic host_en,
    output fctm_pkg::fctm_meas_t meas
);
    import fctm_pkg::*;
    logic [15:0] cnt_r;
    // values move every cycle so a missed freeze cannot hide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    assign link_ok = link_up;
    // a dead link cannot carry a run permission
    assign host_en = run_req & link_up;
    assign meas = {cnt_r, ~cnt_r, cnt_r ^ 16'h5a5a, cnt_r + 16'h0011, cnt_r - 16'h0003};
endmodule : fctm_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
// register-level bench for the trip manager
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fctm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b1, hs_warn = 1'b0;
    logic link_up = 1'b1, run_req = 1'b0, ribbon = 1'b0, link_ok, host_en, firing, tripped, irq;
    fctm_bus_req_t req = '0;
    fctm_trip_req_t trip = '0;
    fctm_meas_t meas;
    fctm_left_t left;
    fctm_alarm_t alarm;
    fctm_code_t rcode;
    logic [31:0] rdata, a, b;
    int mismatches = 0, checked = 0;

    fctm_host_model u_fctm_host_model (.clk(clk), .rst_n(rst_n), .link_up(link_up), .run_req(run_req),
        .link_ok(link_ok), .host_en(host_en), .meas(meas));
    fctm_trip_mgr #(.LOCKOUT_CYCLES(20)) u_fctm_trip_mgr (.SYS_CLK(clk), .RST_N(rst_n), .BUS_REQ(req),
        .BUS_RDATA(rdata), .TRIP_REQ(trip), .SUPPLY_OK(supply_ok), .HEATSINK_WARN(hs_warn),
        .HOST_LINK_OK(link_ok), .HOST_ENABLE(host_en), .RIBBON_PRESENT(ribbon), .MEAS_LIVE(meas),
        .FIRING_EN(firing), .TRIPPED(tripped), .LEFT_STATUS(left), .RIGHT_CODE(rcode),
        .RIGHT_ALARM(alarm), .IRQ(irq));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task stop_test;
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk) req <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk) req <= '{ad, 32'h0, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic tp(input fctm_code_t c);
        @(posedge clk) trip <= '{1'b1, c};
        @(posedge clk) trip <= '0;
        tk(3);
    endtask : tp

    task automatic st(input logic t, input logic f, input fctm_left_t l, input fctm_code_t c);
        chk("tripped", tripped, t);
        chk("firing", firing, f);
        chk("left", left, l);
        chk("right_code", rcode, c);
    endtask : st

    task automatic rst;
        @(posedge clk) rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tk(2);
    endtask : rst

    task automatic hist(input logic [31:0] e);
        rd(OFF_HIST, a);
        chk("hist", a, e);
    endtask : hist

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    initial begin
        rst();
        st(0, 0, LEFT_INHIBITED, 8'h00);
        rd(OFF_IRQ_MASK, a);
        chk("mask", a, 32'h0);
        hist(32'h0);
        wr(OFF_CTRL, 32'h1);
        tk(3);
        st(0, 1, LEFT_RUNNING, 8'h00);
        wr(OFF_CTRL, 32'h3);
        tk(3);
        chk("host_off", firing, 0);
        @(posedge clk) run_req <= 1'b1;
        tk(3);
        chk("host_on", firing, 1);
        wr(OFF_CTRL, 32'h5);
        tk(3);
        chk("rib_off", firing, 0);
        @(posedge clk) ribbon <= 1'b1;
        tk(3);
        chk("rib_on", firing, 1);
        wr(OFF_CTRL, 32'h7);
        tk(3);
        chk("mode_none", left, LEFT_BLANK);
        chk("mode_none_fire", firing, 0);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_ARM_V, a);
        rd(OFF_ARM_V, b);
        chk("live", a === b, 0);
        tp(8'h40);
        st(1, 0, LEFT_TRIPPED, 8'h40);
        hist(32'h40);
        rd(OFF_ARM_V, a);
        tk(4);
        rd(OFF_ARM_V, b);
        chk("frozen", b, a);
        tp(8'h41);
        chk("equal_cls", rcode, 8'h40);
        wr(OFF_RESET, 32'h1);
        tk(3);
        chk("lockout", tripped, 1);
        tk(20);
        wr(OFF_RESET, 32'h1);
        tk(3);
        st(0, 1, LEFT_RUNNING, 8'h00);
        @(posedge clk) supply_ok <= 1'b0;
        tp(8'h40);
        tp(8'h30);
        chk("uv_wins", rcode, 8'h30);
        hist(32'h00404030);
        tk(25);
        wr(OFF_RESET, 32'h1);
        tk(3);
        chk("uv_hold", tripped, 1);
        @(posedge clk) supply_ok <= 1'b1;
        tk(3);
        chk("uv_auto", tripped, 0);
        tp(8'h31);
        wr(OFF_RESET, 32'h1);
        tk(3);
        chk("eef_hold", tripped, 1);
        wr(OFF_CODE, 32'h3e8);
        tk(3);
        chk("fail", alarm, AL_FAIL);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CODE, 32'h3e8);
        wr(OFF_RESET, 32'h1);
        tk(3);
        st(0, 0, LEFT_INHIBITED, 8'h00);
        hist(32'h40403031);
        chk("irq_masked", irq, 0);
        wr(OFF_IRQ_MASK, 32'h4);
        tk(2);
        chk("irq_on", irq, 1);
        wr(OFF_IRQ_STAT, 32'h4);
        tk(2);
        chk("irq_w1c", irq, 0);
        @(posedge clk) link_up <= 1'b0;
        tk(3);
        chk("link", alarm, AL_LINK);
        wr(OFF_IRQ_MASK, 32'h8);
        tk(2);
        chk("irq_link", irq, 1);
        @(posedge clk) link_up <= 1'b1;
        hs_warn <= 1'b1;
        tk(3);
        chk("hot", alarm, AL_HOT);
        wr(OFF_IRQ_STAT, 32'h1f);
        tk(2);
        chk("irq_off", irq, 0);
        rd(8'hfc, a);
        chk("unmapped", a, 32'h0);
        tp(8'h11);
        tk(25);
        wr(OFF_RESET, 32'h1);
        tk(3);
        chk("cls3", tripped, 1);
        tp(8'h01);
        tk(25);
        wr(OFF_RESET, 32'h1);
        tk(3);
        st(1, 0, LEFT_TRIPPED, 8'h01);
        hist(32'h30311101);
        rst();
        st(0, 0, LEFT_INHIBITED, 8'h00);
        hist(32'h0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
